// ===== rtl/sas_pkg.sv
// Summary of operation
// - Conversion clock from 6-bit divider setting
// - Sample period is acquisition plus 14 clocks
// - Software trigger: clearing sample request converts
// - All-ones trigger code selects auto-convert
// - Auto-convert counts sample-time clocks before converting
// - Sample time one gives exactly one clock
// - Auto-sample enable starts sampling without software
// - Samples-per-irq sets conversions per interrupt
// - After count: store results, set flags
// - Module on keeps converter powered unless it powers down in sleep
// - Module off disables digital and analog parts
// - Sleep stops non-RC converter clocks, held low
// - Sleep aborts a non-RC conversion, never resumed
// - Registers keep contents across sleep
// - Sleep conversion only with RC clock
// - RC clock: wait one instruction cycle
// - Sleep-time sequence completion sets done flag
// - Sleep completion with interrupt enabled wakes
// - Else power down, module-on stays set
package sas_pkg;
  // Register byte offsets
  localparam logic [7:0] SAS_ADDR_CTRL = 8'h00;
  localparam logic [7:0] SAS_ADDR_CFG = 8'h04;
  localparam logic [7:0] SAS_ADDR_STAT = 8'h08;
  localparam logic [7:0] SAS_ADDR_CHAN = 8'h0c;
  localparam logic [7:0] SAS_ADDR_BUF = 8'h40;
  // Control field positions
  localparam int SAS_CTRL_ON = 0;
  localparam int SAS_CTRL_AUTO_SAMPLE_EN = 1;
  localparam int SAS_CTRL_SAMPLE_REQUEST = 2;
  localparam int SAS_CTRL_RC = 3;
  localparam int SAS_CTRL_TRIG = 4;
  localparam int SAS_CTRL_IRQEN = 7;
  // Configuration field positions
  localparam int SAS_CFG_DIV = 0;
  localparam int SAS_CFG_SAMPLE_TIME_COUNT = 8;
  localparam int SAS_CFG_SAMPLES_PER_IRQ = 16;
  // Status field positions
  localparam int SAS_STAT_DONE = 0;
  localparam int SAS_STAT_IRQF = 1;
  localparam int SAS_STAT_PDOWN = 2;
  localparam int SAS_STAT_STATE = 4;
  localparam int SAS_STAT_IDX = 8;
  // Trigger codes
  localparam logic [2:0] SAS_TRIG_SW = 3'h0;
  localparam logic [2:0] SAS_TRIG_AUTO = 3'h7;
  // Reset values
  localparam logic [5:0] SAS_DIV_RST = 6'h00;
  localparam logic [4:0] SAS_SAMPLE_TIME_COUNT_RST = 5'h00;
  localparam logic [3:0] SAS_SAMPLES_PER_IRQ_RST = 4'h0;
  // Timing
  localparam int SAS_CONV_TADS = 14;
  localparam int SAS_CLK_NS = 10;
  localparam int SAS_TCY_NS = 20;
  localparam int SAS_TCY_CLKS = (SAS_TCY_NS + SAS_CLK_NS - 1) / SAS_CLK_NS;
  localparam int SAS_RC_TAD_NS = 1500;
  localparam int SAS_RC_TAD_CLKS = SAS_RC_TAD_NS / SAS_CLK_NS;
  localparam int SAS_RES_BITS = 12;

  typedef enum logic [1:0] {SAS_IDLE, SAS_SAMPLE, SAS_RCWAIT, SAS_CONV} sas_state_t;

  typedef struct packed {
    logic power_en;
    logic sample;
    logic convert;
    logic conv_clk;
    logic [3:0] channel;
    logic [SAS_RES_BITS-1:0] dac_code;
  } sas_ana_t;
endpackage

// ===== rtl/sas_tad_gen.sv
`timescale 1ns/1ns
module sas_tad_gen import sas_pkg::*; #(
  parameter int CW = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic en,
  input wire logic restart,
  input wire logic [CW-1:0] period_m1,
  // Tick
  output logic tick
);
  if (CW < 8) begin : g_chk
    $error("sas_tad_gen: CW must hold the RC period");
  end

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic wrap;

  assign wrap = (cnt_q >= period_m1);
  // Restart only clears the count; gating the tick with it loops back through the sequencer
  assign tick = en & wrap;
  assign cnt_d = (!en || restart || wrap) ? '0 : cnt_q + 1'b1;

  // Stopped counter holds the clock low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) cnt_q <= '0;
    else cnt_q <= cnt_d;
  end
endmodule // sas_tad_gen

// ===== rtl/sas_sar.sv
`timescale 1ns/1ns
module sas_sar import sas_pkg::*; #(
  parameter int WIDTH = SAS_RES_BITS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic tick,
  input wire logic cmp,
  // Result
  output logic done,
  output logic [WIDTH-1:0] code,
  output logic [WIDTH-1:0] dac
);
  if (WIDTH < 2 || WIDTH > SAS_CONV_TADS - 2) begin : g_chk
    $error("sas_sar: WIDTH must leave room in the conversion");
  end

  logic [3:0] cnt_q;
  logic [WIDTH-1:0] code_q;
  logic [WIDTH-1:0] trial;
  logic deciding;
  logic last;

  assign deciding = (cnt_q < 4'(WIDTH));
  assign last = (cnt_q == 4'(SAS_CONV_TADS - 1));
  assign trial = deciding ? WIDTH'(1) << (WIDTH - 1 - int'(cnt_q)) : '0;
  assign dac = code_q | trial;
  assign code = code_q;
  assign done = tick & last & ~abort;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      code_q <= '0;
    end else if (start || abort) begin
      cnt_q <= '0;
      code_q <= '0;
    end else if (tick && !last) begin
      cnt_q <= cnt_q + 4'h1;
      if (deciding && cmp) code_q <= code_q | trial;
    end
  end
endmodule // sas_sar

// ===== rtl/sas_adc_seq.sv
`timescale 1ns/1ns
module sas_adc_seq import sas_pkg::*; #(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Processor side
  input wire logic cpu_sleep,
  output logic done_flag,
  output logic conv_irq_flag,
  output logic wake_req,
  // Analog side
  input wire logic cmp_in,
  output sas_ana_t ana
);
  if (DEPTH != 16) begin : g_chk
    $error("sas_adc_seq: DEPTH must match the 4-bit sample count");
  end

  // Control registers
  logic on_q;
  logic auto_sample_en_q;
  logic sample_request_q;
  logic sample_request_d;
  logic rc_q;
  logic irqen_q;
  logic [2:0] trig_q;
  logic [5:0] div_q;
  logic [4:0] sample_time_count_q;
  logic [3:0] samples_per_irq_q;
  logic [3:0] chan_q;

  // Status and sequencing
  logic done_q;
  logic done_d;
  logic irqf_q;
  logic irqf_d;
  logic pdown_q;
  logic pdown_d;
  logic wake_q;
  logic [3:0] idx_q;
  logic [3:0] idx_d;
  logic [4:0] samcnt_q;
  logic [1:0] rcw_q;
  sas_state_t state_q;
  sas_state_t state_d;
  logic [SAS_RES_BITS-1:0] buf_q [DEPTH];
  sas_ana_t ana_q;
  sas_ana_t ana_d;

  // Bus
  logic [31:0] prdata_q;
  logic slverr_q;
  logic [31:0] rd_data;
  logic wr;
  logic setup;
  logic hit_ctrl;
  logic hit_cfg;
  logic hit_stat;
  logic hit_chan;
  logic hit_buf;
  logic wr_ctrl;
  logic wr_cfg;
  logic wr_stat;
  logic wr_chan;

  // Comparator synchroniser
  logic cmp_s1_q;
  logic cmp_s2_q;

  // Event wires
  logic run;
  logic sleep_halt;
  logic tad_tick;
  logic trig_end;
  logic sample_request_start;
  logic sar_start;
  logic sar_done;
  logic seq_done;
  logic last_sample;
  logic set_done;
  logic rcw_end;
  logic [7:0] tad_period;
  logic [SAS_RES_BITS-1:0] sar_code;
  logic [SAS_RES_BITS-1:0] sar_dac;

  // APB decode, zero wait states
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign hit_ctrl = (paddr == SAS_ADDR_CTRL);
  assign hit_cfg = (paddr == SAS_ADDR_CFG);
  assign hit_stat = (paddr == SAS_ADDR_STAT);
  assign hit_chan = (paddr == SAS_ADDR_CHAN);
  assign hit_buf = (paddr[7:6] == SAS_ADDR_BUF[7:6]) && (paddr[1:0] == 2'h0);
  assign wr_ctrl = wr & hit_ctrl;
  assign wr_cfg = wr & hit_cfg;
  assign wr_stat = wr & hit_stat;
  assign wr_chan = wr & hit_chan;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = slverr_q;

  assign rd_data =
    hit_ctrl ? {24'h0, irqen_q, trig_q, rc_q, sample_request_q, auto_sample_en_q, on_q} :
    hit_cfg ? {12'h0, samples_per_irq_q, 3'h0, sample_time_count_q, 2'h0, div_q} :
    hit_stat ? {20'h0, idx_q, 2'h0, state_q, 1'b0, pdown_q, irqf_q, done_q} :
    hit_chan ? {28'h0, chan_q} :
    hit_buf ? {20'h0, buf_q[paddr[5:2]]} :
    32'h0;

  // Read data captured in setup so it comes from flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0;
      slverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0 : rd_data;
      slverr_q <= ~(hit_ctrl | hit_cfg | hit_stat | hit_chan | hit_buf);
    end
  end

  // Configuration writes; nothing here looks at sleep
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      on_q <= 1'b0;
      auto_sample_en_q <= 1'b0;
      rc_q <= 1'b0;
      irqen_q <= 1'b0;
      trig_q <= SAS_TRIG_SW;
    end else if (wr_ctrl) begin
      on_q <= pwdata[SAS_CTRL_ON];
      auto_sample_en_q <= pwdata[SAS_CTRL_AUTO_SAMPLE_EN];
      rc_q <= pwdata[SAS_CTRL_RC];
      irqen_q <= pwdata[SAS_CTRL_IRQEN];
      trig_q <= pwdata[SAS_CTRL_TRIG +: 3];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= SAS_DIV_RST;
      sample_time_count_q <= SAS_SAMPLE_TIME_COUNT_RST;
      samples_per_irq_q <= SAS_SAMPLES_PER_IRQ_RST;
    end else if (wr_cfg) begin
      div_q <= pwdata[SAS_CFG_DIV +: 6];
      sample_time_count_q <= pwdata[SAS_CFG_SAMPLE_TIME_COUNT +: 5];
      samples_per_irq_q <= pwdata[SAS_CFG_SAMPLES_PER_IRQ +: 4];
    end
  end

  // Changing channel mid-sample restarts nothing; caller must resample
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) chan_q <= 4'h0;
    else if (wr_chan) chan_q <= pwdata[3:0];
  end

  // Converter may run
  assign sleep_halt = cpu_sleep & ~rc_q;
  assign run = on_q & ~pdown_q & ~sleep_halt;

  // Conversion clock source
  assign tad_period = rc_q ? 8'(SAS_RC_TAD_CLKS - 1) : {2'h0, div_q};

  sas_tad_gen #(
    .CW(8)
  ) u_tad (
    .clock(clock),
    .rst_n(rst_n),
    .en(run),
    .restart(sample_request_start | sar_start),
    .period_m1(tad_period),
    .tick(tad_tick)
  );

  // Acquisition end
  assign trig_end =
    ((trig_q == SAS_TRIG_SW) & ~sample_request_q) |
    ((trig_q == SAS_TRIG_AUTO) & tad_tick & ((samcnt_q + 5'h1) >= sample_time_count_q));
  assign rcw_end = (rcw_q == 2'(SAS_TCY_CLKS - 1));

  always_comb begin
    state_d = state_q;
    sample_request_start = 1'b0;
    if (!run) begin
      state_d = SAS_IDLE;
    end else begin
      unique case (state_q)
        SAS_IDLE: begin
          if (auto_sample_en_q || sample_request_q) begin
            state_d = SAS_SAMPLE;
            sample_request_start = 1'b1;
          end
        end
        SAS_SAMPLE: begin
          if (trig_end) begin
            state_d = rc_q ? SAS_RCWAIT : SAS_CONV;
          end
        end
        SAS_RCWAIT: begin
          if (rcw_end) begin
            state_d = SAS_CONV;
          end
        end
        SAS_CONV: begin
          if (sar_done) begin
            // Power-down at completion beats the auto restart
            state_d = (auto_sample_en_q && !pdown_d) ? SAS_SAMPLE : SAS_IDLE;
            sample_request_start = auto_sample_en_q & ~pdown_d;
          end
        end
      endcase
    end
  end

  assign sar_start = (state_d == SAS_CONV) && (state_q != SAS_CONV);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) state_q <= SAS_IDLE;
    else state_q <= state_d;
  end

  // Acquisition clock count
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) samcnt_q <= 5'h0;
    else if (sample_request_start) samcnt_q <= 5'h0;
    else if (tad_tick && state_q == SAS_SAMPLE) samcnt_q <= samcnt_q + 5'h1;
  end

  // One instruction cycle before an RC conversion
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) rcw_q <= 2'h0;
    else if (state_q == SAS_RCWAIT) rcw_q <= rcw_q + 2'h1;
    else rcw_q <= 2'h0;
  end

  // Sample request: hardware set on auto start, cleared at conversion
  always_comb begin
    sample_request_d = sample_request_q;
    if (wr_ctrl) sample_request_d = pwdata[SAS_CTRL_SAMPLE_REQUEST];
    if (sar_start && trig_q != SAS_TRIG_SW) sample_request_d = 1'b0;
    if (sample_request_start && auto_sample_en_q) sample_request_d = 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) sample_request_q <= 1'b0;
    else sample_request_q <= sample_request_d;
  end

  // Comparator from analog domain
  // Trial to decision takes three clocks, so a period needs four
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end else begin
      cmp_s1_q <= cmp_in;
      cmp_s2_q <= cmp_s1_q;
    end
  end

  sas_sar #(
    .WIDTH(SAS_RES_BITS)
  ) u_sar (
    .clock(clock),
    .rst_n(rst_n),
    .start(sar_start),
    .abort(~run),
    .tick(tad_tick & (state_q == SAS_CONV)),
    .cmp(cmp_s2_q),
    .done(sar_done),
    .code(sar_code),
    .dac(sar_dac)
  );

  // Sequence count and flags
  assign seq_done = sar_done & (state_q == SAS_CONV);
  assign last_sample = (idx_q == samples_per_irq_q);
  assign set_done = seq_done & last_sample;
  assign idx_d = !on_q ? 4'h0 :
    seq_done ? (last_sample ? 4'h0 : idx_q + 4'h1) : idx_q;

  // Set wins over a clear in the same cycle
  assign done_d = set_done | (done_q & ~(wr_stat & pwdata[SAS_STAT_DONE]));
  assign irqf_d = set_done | (irqf_q & ~(wr_stat & pwdata[SAS_STAT_IRQF]));

  // Powered down until sleep ends or the module is turned off
  assign pdown_d = (set_done & cpu_sleep & ~irqen_q) |
    (pdown_q & cpu_sleep & on_q);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= 4'h0;
      done_q <= 1'b0;
      irqf_q <= 1'b0;
      pdown_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      idx_q <= idx_d;
      done_q <= done_d;
      irqf_q <= irqf_d;
      pdown_q <= pdown_d;
      wake_q <= set_done & cpu_sleep & irqen_q;
    end
  end

  // Result buffer; aborted conversions never reach it
  always_ff @(posedge clock) begin
    if (seq_done) buf_q[idx_q] <= sar_code;
  end

  assign done_flag = done_q;
  assign conv_irq_flag = irqf_q;
  assign wake_req = wake_q;

  // Analog controls, all registered
  always_comb begin
    ana_d.power_en = on_q & ~pdown_q;
    ana_d.sample = run & (state_q == SAS_SAMPLE);
    ana_d.convert = run & (state_q == SAS_CONV);
    ana_d.conv_clk = tad_tick;
    ana_d.channel = chan_q;
    ana_d.dac_code = (state_q == SAS_CONV) ? sar_dac : '0;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) ana_q <= '0;
    else ana_q <= ana_d;
  end

  assign ana = ana_q;
endmodule // sas_adc_seq

// ===== sim/sas_adc_seq_asserts.sv
`timescale 1ns/1ns
module sas_adc_seq_asserts import sas_pkg::*; #(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  // Processor and analog
  input wire logic cpu_sleep,
  input wire logic done_flag,
  input wire logic conv_irq_flag,
  input wire logic wake_req,
  input wire sas_ana_t ana
);
  logic [7:0] ctrl_q;
  wire wr_en = psel && penable && pwrite;
  wire halt = cpu_sleep && !ctrl_q[3];
  wire clr_done = wr_en && paddr == SAS_ADDR_STAT && pwdata[0];
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Shadow of control, so checks need no bus read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= 8'h00;
    end else if (wr_en && paddr == SAS_ADDR_CTRL) begin
      ctrl_q <= pwdata[7:0];
    end
  end
  a_off_quiet: assert property (
    !ctrl_q[0] [*3] |-> !ana.power_en && !ana.sample && !ana.convert) else $error("active while off");
  a_run_powered: assert property (
    ana.sample || ana.convert |-> ana.power_en) else $error("running unpowered");
  a_sleep_clk_low: assert property (
    halt [*3] |-> !ana.conv_clk) else $error("clock runs in sleep");
  a_sleep_abort: assert property (
    halt [*3] |-> !ana.convert && !ana.sample) else $error("no abort in sleep");
  a_wake_cause: assert property (
    wake_req |-> done_flag && ctrl_q[7] && $past(cpu_sleep)) else $error("bad wake");
  a_wake_pulse: assert property (
    wake_req |=> !wake_req) else $error("wake too long");
  a_irq_done: assert property (
    $rose(conv_irq_flag) |-> done_flag) else $error("irq without done");
  a_done_sticky: assert property (
    done_flag && !clr_done |=> done_flag) else $error("done lost");
  a_phase_excl: assert property (
    ana.convert |-> !ana.sample) else $error("sample during convert");
endmodule // sas_adc_seq_asserts

bind sas_adc_seq sas_adc_seq_asserts #(.DEPTH(DEPTH)) u_chk (.clock, .rst_n, .paddr, .psel,
  .penable, .pwrite, .pwdata, .cpu_sleep, .done_flag, .conv_irq_flag, .wake_req, .ana);

// ===== sim/sas_ana_model.sv
`timescale 1ns/1ns
module sas_ana_model import sas_pkg::*; (
  // Clock
  input wire logic clock,
  // Converter side
  input wire sas_ana_t ana,
  input wire logic [11:0] vin,
  output logic cmp_in
);
  logic toggle_q = 1'b0;
  // Outside conversion the comparator output is junk, never a held value
  always_ff @(posedge clock) toggle_q <= ~toggle_q;
  assign cmp_in = ana.convert ? (vin >= ana.dac_code) : toggle_q;
endmodule // sas_ana_model

// ===== sim/tb_top.sv
`timescale 1ns/1ns
module tb_top import sas_pkg::*;;
  logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic cpu_sleep = 1'b0, pready, pslverr, err, done_flag, conv_irq_flag, wake_req, cmp_in;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [11:0] vin = 12'h5a3;
  sas_ana_t ana;
  int failures = 0, comparisons = 0, cyc = 0, t0, n;
  // Dividers stay at three or more: the comparator path is three clocks late
  int tdiv[3] = '{3, 5, 4}, tsam[3] = '{1, 1, 4}, tsmp[3] = '{0, 1, 0};
  initial forever #5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  sas_adc_seq dut (.clock, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .cpu_sleep, .done_flag, .conv_irq_flag, .wake_req, .cmp_in, .ana);
  sas_ana_model u_ana (.clock, .ana, .vin, .cmp_in);
  task automatic end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One full transfer; the edge before setup keeps drives apart
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Waits on done, wake or convert
  task automatic wait_sig(input int k, input int lim);
    logic [2:0] v;
    n = 0;
    do begin
      @(posedge clock);
      v = {ana.convert, wake_req, done_flag};
      if (++n > lim) begin
        failures++;
        end_of_test();
      end
    end while (v[k] !== 1'b1);
  endtask
  task automatic power_up(input logic [31:0] c);
    apb(1, SAS_ADDR_CTRL, 32'h0);
    apb(1, SAS_ADDR_STAT, 32'h3);
    apb(1, SAS_ADDR_CTRL, 32'h1);
    repeat (20) @(posedge clock);
    apb(1, SAS_ADDR_CTRL, c);
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    apb(0, SAS_ADDR_CFG, 0);
    cmp(rd, {12'h0, SAS_SAMPLES_PER_IRQ_RST, 3'h0, SAS_SAMPLE_TIME_COUNT_RST, 2'h0, SAS_DIV_RST});
    apb(0, 8'h10, 0);
    cmp(32'(err), 1);
    cmp(rd, 0);
    apb(1, SAS_ADDR_CHAN, 32'h9);
    apb(0, SAS_ADDR_CHAN, 0);
    cmp(rd, 32'h9);
    cmp(32'(ana.channel), 32'h9);
    $display("reset test done");
    for (int i = 0; i < 3; i++) begin
      vin <= 12'(12'h5a3 + 273 * i);
      apb(1, SAS_ADDR_CTRL, 32'h0);
      apb(1, SAS_ADDR_CFG, (tsmp[i] << 16) | (tsam[i] << 8) | tdiv[i]);
      power_up(32'h73);
      wait_sig(0, 4000);
      cmp(32'(conv_irq_flag), 1);
      apb(1, SAS_ADDR_STAT, 32'h3);
      wait_sig(0, 4000);
      t0 = cyc;
      apb(1, SAS_ADDR_STAT, 32'h3);
      wait_sig(0, 4000);
      cmp(cyc - t0, (tsam[i] + SAS_CONV_TADS) * (tdiv[i] + 1) * (tsmp[i] + 1));
      apb(0, SAS_ADDR_BUF, 0);
      cmp(rd, 32'(vin));
      $display("auto test %0d done", i);
    end
    power_up(32'h5);
    repeat (100) @(posedge clock);
    cmp(32'(done_flag), 0);
    apb(1, SAS_ADDR_CTRL, 32'h1);
    wait_sig(0, 500);
    apb(0, SAS_ADDR_BUF, 0);
    cmp(rd, 32'(vin));
    $display("software trigger test done");
    power_up(32'h73);
    wait_sig(2, 500);
    cpu_sleep <= 1'b1;
    apb(0, SAS_ADDR_CTRL, 0);
    cmp(rd, 32'h73);
    repeat (100) @(posedge clock);
    cmp(32'(done_flag), 0);
    cpu_sleep <= 1'b0;
    apb(0, SAS_ADDR_CTRL, 0);
    cmp(rd, 32'h77);
    $display("sleep abort test done");
    power_up(32'hfb);
    cpu_sleep <= 1'b1;
    wait_sig(1, 6000);
    cmp(32'(done_flag), 1);
    cpu_sleep <= 1'b0;
    power_up(32'h7b);
    cpu_sleep <= 1'b1;
    wait_sig(0, 6000);
    repeat (3) @(posedge clock);
    apb(0, SAS_ADDR_STAT, 0);
    cmp(32'(rd[SAS_STAT_PDOWN]), 1);
    cmp(32'(ana.power_en), 0);
    apb(0, SAS_ADDR_CTRL, 0);
    cmp(rd, 32'h7b);
    cpu_sleep <= 1'b0;
    $display("sleep conversion test done");
    end_of_test();
  end
endmodule // tb_top
